// ### window_thresh_regs.sv
/*
 Window comparator threshold registers for channels 4 to 6, with the
 channel 5 and 6 comparators, run-length counters and event interrupt.
 Assumes a classic Wishbone master on clk_in and conversion results
 arriving on the same clock, one sample per valid pulse.
*/
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "window_thresh_regs.svh"

module window_thresh_regs (
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       wb_cyc_in,
	input  wire logic                       wb_stb_in,
	input  wire logic                       wb_we_in,
	input  wire logic [9:0]                 wb_adr_in,
	input  wire logic [3:0]                 wb_sel_in,
	input  wire logic [31:0]                wb_dat_in,
	input  wire window_thresh_pkg::sample_t sample_in,
	output logic      [31:0]                wb_dat_out,
	output logic                            wb_ack_out,
	output logic      [3:0]                 event_flags_out,
	output logic                            irq_out
);

	////////////////////////////////////////////////////////////////////
	window_thresh_pkg::bus_state_t state;
	logic [7:0]                    ch4_lower_limit_top_byte;
	window_thresh_pkg::chan_regs_t ch5;
	window_thresh_pkg::chan_regs_t ch6;
	logic [3:0]                    evt_status;
	logic [3:0]                    evt_enable;
	logic [3:0]                    run_cnt [0:3];
	logic [3:0]                    hit;
	logic [3:0]                    evt_pulse;
	logic [7:0]                    idx;
	logic                          wr_stb;
	logic                          rd_stb;
	logic [7:0]                    wbyte;
	logic [31:0]                   next_rdata;
	logic [3:0]                    clr_mask;

	assign idx    = wb_adr_in[9:2];
	assign wbyte  = wb_dat_in[7:0];
	assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0] &&
		(state == window_thresh_pkg::ST_IDLE);
	assign rd_stb = wb_cyc_in && wb_stb_in && !wb_we_in &&
		(state == window_thresh_pkg::ST_IDLE);

	function automatic logic is_idx(input logic [7:0] a, input logic [7:0] b);
		is_idx = (a == b);
	endfunction

	// Comparison in one's of 12 bits: high fires at/above, low at/below
	function automatic logic [1:0] compare(input logic [11:0] v,
		input window_thresh_pkg::chan_regs_t r, input logic armed_hi,
		input logic armed_lo);
		logic [11:0] hi_th;
		logic [11:0] lo_th;
		logic [6:0]  hyst;
		logic [12:0] hi_rel;
		logic [12:0] lo_rel;
		hi_th  = {r.high_upper, r.hyst_high_nib[`NIB_HI_MSB:`NIB_HI_LSB]};
		lo_th  = {r.low_upper, r.count_low_nib[`NIB_HI_MSB:`NIB_HI_LSB]};
		hyst   = {r.hyst_high_nib[`NIB_LO_MSB:`NIB_LO_LSB], 3'h0};
		// Once armed the threshold backs off by the hysteresis
		hi_rel = {1'b0, hi_th} - (armed_hi ? {6'h00, hyst} : 13'h0000);
		lo_rel = {1'b0, lo_th} + (armed_lo ? {6'h00, hyst} : 13'h0000);
		compare[0] = !hi_rel[12] && ({1'b0, v} >= hi_rel);
		compare[1] = ({1'b0, v} <= lo_rel);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Bus handshake: ack one cycle after the request, then wait until the request drops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state      <= window_thresh_pkg::ST_IDLE;
			wb_ack_out <= 1'b0;
		end else begin
			case (state)
				window_thresh_pkg::ST_IDLE: begin
					if (wb_cyc_in && wb_stb_in) begin
						state      <= window_thresh_pkg::ST_ACK;
						wb_ack_out <= 1'b1;
					end
				end
				window_thresh_pkg::ST_ACK: begin
					state      <= window_thresh_pkg::ST_WAIT;
					wb_ack_out <= 1'b0;
				end
				window_thresh_pkg::ST_WAIT: begin
					if (!(wb_cyc_in && wb_stb_in)) begin
						state <= window_thresh_pkg::ST_IDLE;
					end
				end
				default: begin
					state      <= window_thresh_pkg::ST_IDLE;
					wb_ack_out <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Threshold registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ch4_lower_limit_top_byte <= `RST_LOW_LIMIT_UPPER;
			ch5.hyst_high_nib        <= `RST_HYST_HIGH_NIB;
			ch5.high_upper           <= `RST_HIGH_LIMIT_UPPER;
			ch5.count_low_nib        <= `RST_COUNT_LOW_NIB;
			ch5.low_upper            <= `RST_LOW_LIMIT_UPPER;
			ch6.hyst_high_nib        <= `RST_HYST_HIGH_NIB;
			ch6.high_upper           <= `RST_HIGH_LIMIT_UPPER;
			ch6.count_low_nib        <= `RST_COUNT_LOW_NIB;
			ch6.low_upper            <= `RST_LOW_LIMIT_UPPER;
		end else if (wr_stb) begin
			// Each register written alone, whole byte
			if (is_idx(idx, `IDX_CH4_LOW_LIMIT_UPPER))  ch4_lower_limit_top_byte <= wbyte;
			if (is_idx(idx, `IDX_CH5_HYST_HIGH_NIB))    ch5.hyst_high_nib <= wbyte;
			if (is_idx(idx, `IDX_CH5_HIGH_LIMIT_UPPER)) ch5.high_upper <= wbyte;
			if (is_idx(idx, `IDX_CH5_COUNT_LOW_NIB))    ch5.count_low_nib <= wbyte;
			if (is_idx(idx, `IDX_CH5_LOW_LIMIT_UPPER))  ch5.low_upper <= wbyte;
			if (is_idx(idx, `IDX_CH6_HYST_HIGH_NIB))    ch6.hyst_high_nib <= wbyte;
			if (is_idx(idx, `IDX_CH6_HIGH_LIMIT_UPPER)) ch6.high_upper <= wbyte;
			if (is_idx(idx, `IDX_CH6_COUNT_LOW_NIB))    ch6.count_low_nib <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (idx)
			`IDX_CH4_LOW_LIMIT_UPPER:  next_rdata[7:0] = ch4_lower_limit_top_byte;
			`IDX_CH5_HYST_HIGH_NIB:    next_rdata[7:0] = ch5.hyst_high_nib;
			`IDX_CH5_HIGH_LIMIT_UPPER: next_rdata[7:0] = ch5.high_upper;
			`IDX_CH5_COUNT_LOW_NIB:    next_rdata[7:0] = ch5.count_low_nib;
			`IDX_CH5_LOW_LIMIT_UPPER:  next_rdata[7:0] = ch5.low_upper;
			`IDX_CH6_HYST_HIGH_NIB:    next_rdata[7:0] = ch6.hyst_high_nib;
			`IDX_CH6_HIGH_LIMIT_UPPER: next_rdata[7:0] = ch6.high_upper;
			`IDX_CH6_COUNT_LOW_NIB:    next_rdata[7:0] = ch6.count_low_nib;
			`IDX_EVT_STATUS:           next_rdata[3:0] = evt_status;
			`IDX_EVT_ENABLE:           next_rdata[3:0] = evt_enable;
			default:                   next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_dat_out <= 32'h0000_0000;
		end else if (rd_stb) begin
			wb_dat_out <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Comparators and run-length counters, one per event
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_evt
			window_thresh_pkg::chan_regs_t r;
			logic [2:0]                    ch;
			logic [1:0]                    cmp;
			assign r   = (g < 2) ? ch5 : ch6;
			assign ch  = (g < 2) ? 3'h5 : 3'h6;
			assign cmp = compare(sample_in.value, r, evt_status[g & 2],
				evt_status[(g & 2) + 1]);
			assign hit[g] = cmp[g % 2];
			// Counter reaches n after n qualifying samples; the event fires on sample n+1
			assign evt_pulse[g] = sample_in.valid && (sample_in.chan == ch) && hit[g] &&
				(run_cnt[g] >= r.count_low_nib[`NIB_LO_MSB:`NIB_LO_LSB]);
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					run_cnt[g] <= 4'h0;
				end else if (sample_in.valid && (sample_in.chan == ch)) begin
					if (!hit[g]) begin
						run_cnt[g] <= 4'h0;
					end else if (run_cnt[g] != 4'hF) begin
						run_cnt[g] <= run_cnt[g] + 4'h1;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Event status, enable and interrupt; a new event beats a clear
	assign clr_mask = (wr_stb && is_idx(idx, `IDX_EVT_CLEAR)) ? wb_dat_in[3:0] : 4'h0;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			evt_status <= 4'h0;
		end else begin
			evt_status <= (evt_status & ~clr_mask) | evt_pulse;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			evt_enable <= 4'h0;
		end else if (wr_stb && is_idx(idx, `IDX_EVT_ENABLE)) begin
			evt_enable <= wb_dat_in[3:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_out         <= 1'b0;
			event_flags_out <= 4'h0;
		end else begin
			irq_out         <= |(evt_status & evt_enable);
			event_flags_out <= evt_status;
		end
	end

endmodule

// ### window_thresh_regs.svh
`ifndef WINDOW_THRESH_REGS_SVH
`define WINDOW_THRESH_REGS_SVH
// Register indices as printed; byte address is four times the index
`define IDX_CH4_LOW_LIMIT_UPPER   8'h33
`define IDX_CH5_HYST_HIGH_NIB     8'h34
`define IDX_CH5_HIGH_LIMIT_UPPER  8'h35
`define IDX_CH5_COUNT_LOW_NIB     8'h36
`define IDX_CH5_LOW_LIMIT_UPPER   8'h37
`define IDX_CH6_HYST_HIGH_NIB     8'h38
`define IDX_CH6_HIGH_LIMIT_UPPER  8'h39
`define IDX_CH6_COUNT_LOW_NIB     8'h3A
// Interrupt registers
`define IDX_EVT_STATUS            8'h40
`define IDX_EVT_CLEAR             8'h41
`define IDX_EVT_ENABLE            8'h42
// Reset values
`define RST_HYST_HIGH_NIB         8'hF0
`define RST_HIGH_LIMIT_UPPER      8'hFF
`define RST_COUNT_LOW_NIB         8'h00
`define RST_LOW_LIMIT_UPPER       8'h00
// Field positions
`define NIB_HI_MSB                7
`define NIB_HI_LSB                4
`define NIB_LO_MSB                3
`define NIB_LO_LSB                0
`define HYST_SHIFT                3
// Event bits in status/enable
`define EVT_CH5_HIGH              0
`define EVT_CH5_LOW               1
`define EVT_CH6_HIGH              2
`define EVT_CH6_LOW               3
`endif

// ### window_thresh_pkg.sv
/*
 Types for the window threshold register slice.
 Assumes the constants header is included by the design.
*/
package window_thresh_pkg;
	typedef struct packed {
		logic [7:0] hyst_high_nib;
		logic [7:0] high_upper;
		logic [7:0] count_low_nib;
		logic [7:0] low_upper;
	} chan_regs_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chan;
		logic [11:0] value;
	} sample_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ACK  = 3'b010,
		ST_WAIT = 3'b100
	} bus_state_t;
endpackage

// ### window_thresh_regs_chk.sv
/*
 Port checker for the window threshold register slice.
 Assumes one clock, asynchronous active-low reset, bound by the line at the foot.
*/
`timescale 1ns/1ns
module window_thresh_regs_chk (
	input wire logic                       clk_in,
	input wire logic                       rst_n_in,
	input wire logic                       wb_cyc_in,
	input wire logic                       wb_stb_in,
	input wire logic                       wb_we_in,
	input wire logic [9:0]                 wb_adr_in,
	input wire window_thresh_pkg::sample_t sample_in,
	input wire logic [31:0]                wb_dat_out,
	input wire logic                       wb_ack_out,
	input wire logic [3:0]                 event_flags_out,
	input wire logic                       irq_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////////////////
	property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_ack_late; $rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out; endproperty
	a_ack_late: assert property (p_ack_late) else $error("ack not one cycle after request");
	property p_dat_hold; $changed(wb_dat_out) |-> wb_ack_out && !wb_we_in; endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved outside a read");
	property p_gap_zero;
		wb_ack_out && !wb_we_in && (wb_adr_in == 10'h0EC || wb_adr_in == 10'h104) |-> wb_dat_out == 0;
	endproperty
	a_gap_zero: assert property (p_gap_zero) else $error("unmapped read not zero");
	property p_irq_flags; irq_out |-> event_flags_out != 4'h0; endproperty
	a_irq_flags: assert property (p_irq_flags) else $error("irq with no flag");
	property p_rise5;
		$rose(event_flags_out[0]) || $rose(event_flags_out[1])
		|-> $past(sample_in.valid, 2) && $past(sample_in.chan, 2) == 3'h5;
	endproperty
	a_rise5: assert property (p_rise5) else $error("ch5 flag without ch5 sample");
	property p_rise6;
		$rose(event_flags_out[2]) || $rose(event_flags_out[3])
		|-> $past(sample_in.valid, 2) && $past(sample_in.chan, 2) == 3'h6;
	endproperty
	a_rise6: assert property (p_rise6) else $error("ch6 flag without ch6 sample");
	property p_flag_cause;
		event_flags_out != $past(event_flags_out)
		|-> $past(sample_in.valid, 2) || $past(wb_cyc_in && wb_we_in, 2);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flags moved with no cause");
	c_write: cover property (wb_ack_out && wb_we_in);
	c_read: cover property (wb_ack_out && !wb_we_in);
	c_irq: cover property ($rose(irq_out));
endmodule
bind window_thresh_regs window_thresh_regs_chk u_chk (.clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
	.wb_we_in, .wb_adr_in, .sample_in, .wb_dat_out, .wb_ack_out, .event_flags_out, .irq_out);

// ### window_thresh_regs_test.sv
/*
 Self-checking bench for the window threshold register slice.
 Assumes the design answers one cycle after a request, as its note says.
*/
`timescale 1ns/1ns
module window_thresh_regs_test;
	logic                       clk_in = 1'b0;
	logic                       rst_n_in = 1'b0;
	logic                       wb_cyc = 1'b0;
	logic                       wb_stb = 1'b0;
	logic                       wb_we = 1'b0;
	logic [9:0]                 wb_adr = 10'h000;
	logic [31:0]                wb_wdat = 32'h0;
	logic [31:0]                wb_rdat;
	logic [31:0]                q;
	logic                       wb_ack;
	logic                       irq;
	logic [3:0]                 flags;
	window_thresh_pkg::sample_t smp = '0;
	logic [11:0]                seq [9] = '{12'h805, 12'h805, 12'h804, 12'h805, 12'h805,
		12'h7FF, 12'h805, 12'h805, 12'h805};
	int                         n_errors = 0;
	int                         samples_checked = 0;
	int                         cycles = 0;
	always #4 clk_in = ~clk_in;
	window_thresh_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF),
		.wb_dat_in(wb_wdat), .sample_in(smp), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack),
		.event_flags_out(flags), .irq_out(irq));
	////////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task xfer(input logic we, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_wdat <= {24'h000000, d};
		do @(posedge clk_in); while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task samp(input logic [2:0] ch, input logic [11:0] v);
		@(posedge clk_in);
		smp <= {1'b1, ch, v};
		@(posedge clk_in);
		smp.valid <= 1'b0;
	endtask
	task settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, 8'(8'h33 + i), 8'h00);
			check("reset", q, (i % 4 == 1) ? 32'hF0 : (i % 4 == 2) ? 32'hFF : 32'h0);
		end
		for (int i = 0; i < 8; i++) xfer(1'b1, 8'(8'h33 + i), 8'(8'hA1 + 8'h11 * i));
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, 8'(8'h33 + i), 8'h00);
			check("readback", q, 32'(8'(8'hA1 + 8'h11 * i)));
		end
		xfer(1'b0, 8'h3B, 8'h00);
		check("unmapped", q, 32'h0);
		// Ch5 high limit 0x805, run length 2, low limit 0x403
		xfer(1'b1, 8'h42, 8'h0F);
		xfer(1'b1, 8'h34, 8'h50);
		xfer(1'b1, 8'h35, 8'h80);
		xfer(1'b1, 8'h36, 8'h32);
		xfer(1'b1, 8'h37, 8'h40);
		for (int i = 0; i < 8; i++) samp(3'h5, seq[i]);
		settle;
		check("flags broken run", 32'(flags), 32'h0);
		samp(3'h5, seq[8]);
		settle;
		check("flags run", 32'(flags), 32'h1);
		check("irq", 32'(irq), 32'h1);
		xfer(1'b1, 8'h42, 8'h0E);
		settle;
		check("irq masked", 32'(irq), 32'h0);
		xfer(1'b1, 8'h41, 8'h01);
		settle;
		check("flags cleared", 32'(flags), 32'h0);
		xfer(1'b1, 8'h36, 8'h30);
		samp(3'h5, 12'h404);
		settle;
		check("low miss", 32'(flags), 32'h0);
		samp(3'h5, 12'h403);
		settle;
		check("low hit", 32'(flags), 32'h2);
		// Ch6 high limit 0x800, hysteresis 2 gives 0x10
		xfer(1'b1, 8'h39, 8'h80);
		xfer(1'b1, 8'h38, 8'h02);
		xfer(1'b1, 8'h3A, 8'h00);
		samp(3'h6, 12'h800);
		settle;
		check("ch6 hit", 32'(flags), 32'h6);
		fork
			xfer(1'b1, 8'h41, 8'h04);
			samp(3'h6, 12'h7F0);
		join
		settle;
		check("hyst hold", 32'(flags), 32'h6);
		fork
			xfer(1'b1, 8'h41, 8'h04);
			samp(3'h6, 12'h7EF);
		join
		settle;
		check("hyst drop", 32'(flags), 32'h2);
		tally_and_finish;
	end
endmodule
